// ### inc/spi_flags_pkg.sv
// Register map, field layout and timing constants of the serial port flags.
package spi_flags_pkg;

	// Register byte offsets on the AXI4-Lite slave.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DATA = 8'h04;
	localparam logic [7:0] OFF_CFG  = 8'h08;
	localparam logic [7:0] OFF_MASK = 8'h0c;

	// Control register layout and reset value.
	localparam logic [7:0] CTRL_RESET    = 8'h06;
	localparam int         CTRL_FLAG_LSB = 4;
	localparam int         CTRL_SSM_LSB  = 2;
	localparam int         CTRL_TXE_BIT  = 1;
	localparam int         CTRL_EN_BIT   = 0;

	// Flag vector positions, shared by status and mask.
	localparam int FL_DONE = 3;
	localparam int FL_WRITE_COLLISION_FLAG = 2;
	localparam int FL_MODE_FAULT_FLAG = 1;
	localparam int FL_OVR  = 0;

	// Configuration register layout.
	localparam int CFG_BUSY  = 7;
	localparam int CFG_MASTER_ENABLE = 6;
	localparam int CFG_SEL   = 3;
	localparam int CFG_NSSIN = 2;
	localparam int CFG_SRMT  = 1;
	localparam int CFG_RXBMT = 0;

	// Slave select modes.
	localparam logic [1:0] SSM_3WIRE = 2'h0;
	localparam logic [1:0] SSM_MULTI = 2'h1;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Timing counts in system clock cycles.
	localparam logic [7:0] SCK_HALF_CYCLES = 8'h04;
	localparam int         DEGLITCH_CYCLES = 4;

endpackage : spi_flags_pkg

// ### inc/link_samples_if.sv
// Synchronised link samples passed from the pin sampler to the flag logic.
`timescale 1ns/1ns
interface link_samples_if;
	logic rise;
	logic fall;
	logic mosi;
	logic miso;
	logic nss_raw;
	logic sel;

	modport src (output rise, fall, mosi, miso, nss_raw, sel);
	modport dst (input rise, fall, mosi, miso, nss_raw, sel);
endinterface : link_samples_if

// ### hdl/link_sampler.sv
// Pin synchroniser, clock edge finder and slave select de-glitcher.
`timescale 1ns/1ns
module link_sampler #(
	parameter int DEGLITCH = spi_flags_pkg::DEGLITCH_CYCLES
) (
	// Clock and reset.
	input  wire logic      clk_sys_in,
	input  wire logic      nrst_in,
	// Raw pins.
	input  wire logic      sck_in,
	input  wire logic      mosi_in,
	input  wire logic      miso_in,
	input  wire logic      nss_in,
	// Samples.
	link_samples_if.src    link
);
	typedef struct packed {
		logic [3:0] s1;
		logic [3:0] s2;
		logic       sck_prev;
		logic       rise;
		logic       fall;
		logic [3:0] cnt;
		logic       sel;
	} smp_t;

	smp_t q;
	smp_t d;

	always_comb begin
		d          = q;
		d.s1       = {sck_in, mosi_in, miso_in, nss_in};
		d.s2       = q.s1;
		d.sck_prev = q.s2[3];
		d.rise     = q.s2[3] & ~q.sck_prev;
		d.fall     = ~q.s2[3] & q.sck_prev;
		// Selection follows the pin only after it has held for a while.
		if (q.s2[0] != q.sel) begin
			d.cnt = '0;
		end else if (q.cnt == 4'(DEGLITCH - 1)) begin
			d.cnt = '0;
			d.sel = ~q.s2[0];
		end else begin
			d.cnt = 4'(q.cnt + 4'h1);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			q <= '{s1: 4'h1, s2: 4'h1, default: '0};
		end else begin
			q <= d;
		end
	end

	assign link.rise    = q.rise;
	assign link.fall    = q.fall;
	assign link.mosi    = q.s2[2];
	assign link.miso    = q.s2[1];
	assign link.nss_raw = q.s2[0];
	assign link.sel     = q.sel;

endmodule : link_sampler

// ### hdl/spi_control_flags.sv
// Serial port status flags, slave select modes and AXI4-Lite registers.
`timescale 1ns/1ns

module spi_control_flags #(
	parameter int         ADDR_W   = 8,
	parameter logic [7:0] SCK_HALF = spi_flags_pkg::SCK_HALF_CYCLES
) (
	// Clock and reset.
	input  wire logic              clk_sys_in,
	input  wire logic              nrst_in,
	// AXI4-Lite write channels.
	input  wire logic [ADDR_W-1:0] awaddr_in,
	input  wire logic              awvalid_in,
	output logic                   awready_out,
	input  wire logic [31:0]       wdata_in,
	input  wire logic [3:0]        wstrb_in,
	input  wire logic              wvalid_in,
	output logic                   wready_out,
	output logic [1:0]             bresp_out,
	output logic                   bvalid_out,
	input  wire logic              bready_in,
	// AXI4-Lite read channels.
	input  wire logic [ADDR_W-1:0] araddr_in,
	input  wire logic              arvalid_in,
	output logic                   arready_out,
	output logic [31:0]            rdata_out,
	output logic [1:0]             rresp_out,
	output logic                   rvalid_out,
	input  wire logic              rready_in,
	// Serial bus pins.
	input  wire logic              sck_in,
	output logic                   sck_out,
	output logic                   sck_oe_out,
	input  wire logic              mosi_in,
	output logic                   mosi_out,
	output logic                   mosi_oe_out,
	input  wire logic              miso_in,
	output logic                   miso_out,
	output logic                   miso_oe_out,
	input  wire logic              nss_in,
	output logic                   nss_out,
	output logic                   nss_oe_out,
	// Interrupt.
	output logic                   irq_out
);
	typedef struct packed {
		logic        awready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [3:0]  flags;
		logic [1:0]  ssmode;
		logic        txe;
		logic        en;
		logic        master_enable;
		logic [3:0]  mask;
		logic [7:0]  txbuf;
		logic [7:0]  rxbuf;
		logic        rxfull;
		logic [7:0]  shift;
		logic [2:0]  bits;
		logic        busy;
		logic [7:0]  div;
		logic        sck;
		logic        dout;
		logic        sck_oe;
		logic        mosi_oe;
		logic        miso_oe;
		logic        nss_out;
		logic        nss_oe;
		logic        irq;
	} state_t;

	state_t q;
	state_t d;

	link_samples_if link ();

	link_sampler u_sampler (
		.clk_sys_in (clk_sys_in),
		.nrst_in    (nrst_in),
		.sck_in     (sck_in),
		.mosi_in    (mosi_in),
		.miso_in    (miso_in),
		.nss_in     (nss_in),
		.link       (link.src)
	);

	function automatic logic hit(input logic [ADDR_W-1:0] a,
	                             input logic [7:0] off);
		return a == ADDR_W'(off);
	endfunction : hit

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return hit(a, spi_flags_pkg::OFF_CTRL) ||
		       hit(a, spi_flags_pkg::OFF_DATA) ||
		       hit(a, spi_flags_pkg::OFF_CFG) ||
		       hit(a, spi_flags_pkg::OFF_MASK);
	endfunction : mapped

	// Bus strobes, one cycle each, then shifter select, edge and data signals.
	logic wr_go;
	logic rd_go;
	logic wr_ctrl;
	logic wr_data;
	logic wr_cfg;
	logic wr_mask;
	logic rd_data;
	logic sel_active;
	logic tick;
	logic take;
	logic give;
	logic bit_in;
	logic [7:0] nb;

	assign wr_go   = q.awready & awvalid_in & wvalid_in;
	assign rd_go   = q.arready & arvalid_in;
	assign wr_ctrl = wr_go & wstrb_in[0] & hit(awaddr_in, spi_flags_pkg::OFF_CTRL);
	assign wr_data = wr_go & wstrb_in[0] & hit(awaddr_in, spi_flags_pkg::OFF_DATA);
	assign wr_cfg  = wr_go & wstrb_in[0] & hit(awaddr_in, spi_flags_pkg::OFF_CFG);
	assign wr_mask = wr_go & wstrb_in[0] & hit(awaddr_in, spi_flags_pkg::OFF_MASK);
	assign rd_data = rd_go & hit(araddr_in, spi_flags_pkg::OFF_DATA);

	// In three-wire mode the slave is always selected.
	assign sel_active = (q.ssmode == spi_flags_pkg::SSM_3WIRE) || link.sel;
	assign tick   = q.busy && q.master_enable && (q.div == 8'(SCK_HALF - 8'h01));
	assign take   = q.busy && (q.master_enable ? tick && !q.sck
	                                   : sel_active && link.rise);
	assign give   = q.busy && (q.master_enable ? tick && q.sck
	                                   : sel_active && link.fall);
	assign bit_in = q.master_enable ? link.miso : link.mosi;
	assign nb     = {q.shift[6:0], bit_in};

	always_comb begin
		d         = q;
		d.awready = 1'b0;
		d.arready = 1'b0;

		// Write address and data are taken together, then answered.
		if (!q.awready && !q.bvalid && awvalid_in && wvalid_in) begin
			d.awready = 1'b1;
		end
		if (wr_go) begin
			d.bvalid = 1'b1;
			d.bresp  = mapped(awaddr_in) ? spi_flags_pkg::RESP_OKAY
			                             : spi_flags_pkg::RESP_SLVERR;
		end else if (q.bvalid && bready_in) begin
			d.bvalid = 1'b0;
		end

		if (!q.arready && !q.rvalid && arvalid_in) begin
			d.arready = 1'b1;
		end
		if (rd_go) begin
			d.rvalid = 1'b1;
			d.rresp  = mapped(araddr_in) ? spi_flags_pkg::RESP_OKAY
			                             : spi_flags_pkg::RESP_SLVERR;
			d.rdata  = '0;
			if (hit(araddr_in, spi_flags_pkg::OFF_CTRL)) begin
				d.rdata[spi_flags_pkg::CTRL_FLAG_LSB +: 4] = q.flags;
				d.rdata[spi_flags_pkg::CTRL_SSM_LSB +: 2]  = q.ssmode;
				d.rdata[spi_flags_pkg::CTRL_TXE_BIT]       = q.txe;
				d.rdata[spi_flags_pkg::CTRL_EN_BIT]        = q.en;
			end else if (hit(araddr_in, spi_flags_pkg::OFF_DATA)) begin
				d.rdata[7:0] = q.rxbuf;
			end else if (hit(araddr_in, spi_flags_pkg::OFF_CFG)) begin
				d.rdata[spi_flags_pkg::CFG_BUSY]  = q.busy;
				d.rdata[spi_flags_pkg::CFG_MASTER_ENABLE] = q.master_enable;
				d.rdata[spi_flags_pkg::CFG_SEL]   = link.sel;
				d.rdata[spi_flags_pkg::CFG_NSSIN] = link.nss_raw;
				d.rdata[spi_flags_pkg::CFG_SRMT]  = !q.busy || q.master_enable;
				d.rdata[spi_flags_pkg::CFG_RXBMT] = !q.rxfull || q.master_enable;
			end else if (hit(araddr_in, spi_flags_pkg::OFF_MASK)) begin
				d.rdata[spi_flags_pkg::CTRL_FLAG_LSB +: 4] = q.mask;
			end
		end else if (q.rvalid && rready_in) begin
			d.rvalid = 1'b0;
		end

		// Software effects come first so that hardware events win.
		if (rd_data) begin
			d.rxfull = 1'b0;
		end
		if (wr_ctrl) begin
			d.flags  = q.flags & ~wdata_in[spi_flags_pkg::CTRL_FLAG_LSB +: 4];
			d.ssmode = wdata_in[spi_flags_pkg::CTRL_SSM_LSB +: 2];
			d.en     = wdata_in[spi_flags_pkg::CTRL_EN_BIT];
		end
		if (wr_cfg) begin
			d.master_enable = wdata_in[spi_flags_pkg::CFG_MASTER_ENABLE];
		end
		if (wr_mask) begin
			d.mask = wdata_in[spi_flags_pkg::CTRL_FLAG_LSB +: 4];
		end
		if (wr_data) begin
			if (!q.txe) begin
				d.flags[spi_flags_pkg::FL_WRITE_COLLISION_FLAG] = 1'b1;
			end else begin
				d.txbuf = wdata_in[7:0];
				d.txe   = 1'b0;
			end
		end

		if (q.master_enable && q.ssmode == spi_flags_pkg::SSM_MULTI && link.sel) begin
			d.flags[spi_flags_pkg::FL_MODE_FAULT_FLAG] = 1'b1;
		end

		// Shifter: load, clock edges, completion.
		if (!q.en) begin
			d.busy = 1'b0;
			d.bits = '0;
			d.sck  = 1'b0;
		end else if (!q.busy) begin
			d.sck = 1'b0;
			if ((q.master_enable && !q.txe) || (!q.master_enable && sel_active)) begin
				d.busy = 1'b1;
				d.bits = '0;
				d.div  = '0;
				if (!q.txe) begin
					d.shift = q.txbuf;
					d.txe   = 1'b1;
					d.dout  = q.txbuf[7];
				end else begin
					d.dout = q.shift[7];
				end
			end
		end else if (!q.master_enable && !sel_active) begin
			d.busy = 1'b0;
			d.bits = '0;
		end else begin
			if (q.master_enable) begin
				d.div = tick ? 8'h00 : 8'(q.div + 8'h01);
				if (tick) begin
					d.sck = ~q.sck;
				end
			end
			if (take) begin
				d.shift = nb;
				d.bits  = 3'(q.bits + 3'h1);
				if (q.bits == 3'h7) begin
					d.busy = 1'b0;
					d.flags[spi_flags_pkg::FL_DONE] = 1'b1;
					if (q.rxfull && !q.master_enable) begin
						d.flags[spi_flags_pkg::FL_OVR] = 1'b1;
					end else begin
						d.rxbuf  = nb;
						d.rxfull = 1'b1;
					end
				end
			end else if (give) begin
				d.dout = q.shift[7];
			end
		end

		// Pin drivers.
		d.sck_oe  = q.master_enable && q.en;
		d.mosi_oe = q.master_enable && q.en;
		d.miso_oe = !q.master_enable && q.en && sel_active;
		d.nss_oe  = q.ssmode[1];
		d.nss_out = q.ssmode[0];
		d.irq     = |(d.flags & d.mask);
	end

	always_ff @(posedge clk_sys_in) begin
		if (!nrst_in) begin
			q <= '{ssmode: spi_flags_pkg::CTRL_RESET[3:2],
			       txe:    spi_flags_pkg::CTRL_RESET[1],
			       default: '0};
		end else begin
			q <= d;
		end
	end

	assign awready_out = q.awready;
	assign wready_out  = q.awready;
	assign bvalid_out  = q.bvalid;
	assign bresp_out   = q.bresp;
	assign arready_out = q.arready;
	assign rvalid_out  = q.rvalid;
	assign rresp_out   = q.rresp;
	assign rdata_out   = q.rdata;
	assign sck_out     = q.sck;
	assign sck_oe_out  = q.sck_oe;
	assign mosi_out    = q.dout;
	assign mosi_oe_out = q.mosi_oe;
	assign miso_out    = q.dout;
	assign miso_oe_out = q.miso_oe;
	assign nss_out     = q.nss_out;
	assign nss_oe_out  = q.nss_oe;
	assign irq_out     = q.irq;

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);

	property p_done_sticky;
		q.flags[spi_flags_pkg::FL_DONE] &&
		!(wr_ctrl && wdata_in[spi_flags_pkg::CTRL_FLAG_LSB + 3])
		|=> q.flags[spi_flags_pkg::FL_DONE];
	endproperty
	a_done_sticky: assert property (p_done_sticky)
		else $error("done flag lost without a clear");

	property p_irq;
		##1 irq_out == |($past(d.flags) & $past(d.mask));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt does not follow unmasked flags");

	property p_write_collision_flag;
		wr_data && !q.txe |=> q.flags[spi_flags_pkg::FL_WRITE_COLLISION_FLAG];
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag)
		else $error("collision flag not set");

	property p_discard;
		wr_data && !q.txe |=> $stable(q.txbuf);
	endproperty
	a_discard: assert property (p_discard)
		else $error("colliding write changed transmit buffer");

	property p_mode_fault_flag;
		q.master_enable && q.ssmode == spi_flags_pkg::SSM_MULTI && link.sel
		|=> q.flags[spi_flags_pkg::FL_MODE_FAULT_FLAG];
	endproperty
	a_mode_fault_flag: assert property (p_mode_fault_flag)
		else $error("mode fault not flagged");

	property p_nss_pin;
		##1 nss_oe_out == $past(q.ssmode[1]) &&
		(!nss_oe_out || nss_out == $past(q.ssmode[0]));
	endproperty
	a_nss_pin: assert property (p_nss_pin)
		else $error("select pin drive does not match mode");

	property p_txe_clear;
		wr_data && q.txe |=> !q.txe && q.txbuf == $past(wdata_in[7:0]);
	endproperty
	a_txe_clear: assert property (p_txe_clear)
		else $error("transmit empty not cleared by write");

	sequence s_master_ready;
		q.en && q.master_enable && !q.busy && !q.txe;
	endsequence
	sequence s_loaded;
		q.busy && q.txe && q.shift == $past(q.txbuf);
	endsequence
	property p_load;
		s_master_ready |=> s_loaded;
	endproperty
	a_load: assert property (p_load)
		else $error("transmit buffer not moved into shifter");

	property p_overrun;
		q.en && take && q.bits == 3'h7 && q.rxfull && !q.master_enable && !rd_data
		|=> q.flags[spi_flags_pkg::FL_OVR] && $stable(q.rxbuf);
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun not flagged");

endmodule : spi_control_flags

// ### tb/spi_far_end.sv
// Far-end serial device: a master that clocks the port, or a slave to it.
`timescale 1ns/1ns
module spi_far_end (
	// Wire levels.
	input  wire logic  sck_w,
	input  wire logic  mosi_w,
	input  wire logic  nss_w,
	// Far-end drive.
	output logic       sck_far,
	output logic       mosi_far,
	output logic       nss_far,
	output logic       miso_far,
	// Byte captured while acting as slave.
	output logic [7:0] rx_byte
);
	initial begin
		sck_far = 1'b0;
		mosi_far = 1'b0;
		nss_far = 1'b1;
		miso_far = 1'b0;
		rx_byte = 8'h00;
	end

	// Capture on rising edges while selected, most significant bit first.
	always @(posedge sck_w) begin
		if (!nss_w) begin
			rx_byte <= {rx_byte[6:0], mosi_w};
		end
	end

	// The reply line is never driven with data, so it must not look stable.
	always #20 miso_far = ~miso_far;

	task automatic select(input logic lvl);
		nss_far <= lvl;
	endtask : select

	// One byte at 160 ns a bit; the clock stands low outside the frame.
	task automatic send(input logic [7:0] tx);
		// Keep every pin change away from the sampling clock edge.
		#5;
		nss_far = 1'b0;
		#400;
		for (int i = 7; i >= 0; i--) begin
			mosi_far = tx[i];
			#80 sck_far = 1'b1;
			#80 sck_far = 1'b0;
		end
		#200 nss_far = 1'b1;
		mosi_far = ~tx[0];
	endtask : send
endmodule : spi_far_end

// ### tb/spi_control_flags_tb.sv
// Self-checking bench of the serial port flags and select modes.
`timescale 1ns/1ns
module spi_control_flags_tb;
	logic        clk_sys_in = 1'b0;
	logic        nrst_in = 1'b0;
	logic [7:0]  awaddr_in = 8'h00;
	logic [7:0]  araddr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0;
	logic [3:0]  wstrb_in = 4'hf;
	logic        awvalid_in = 1'b0;
	logic        wvalid_in = 1'b0;
	logic        bready_in = 1'b0;
	logic        arvalid_in = 1'b0;
	logic        rready_in = 1'b0;
	logic        awready_out, wready_out, bvalid_out, arready_out;
	logic        rvalid_out, irq_out;
	logic [1:0]  bresp_out, rresp_out;
	logic [31:0] rdata_out;
	logic        sck_out, sck_oe_out, mosi_out, mosi_oe_out;
	logic        miso_out, miso_oe_out, nss_out, nss_oe_out;
	logic        sck_far, mosi_far, nss_far, miso_far;
	logic [7:0]  rx_byte;
	int          num_errors = 0;
	int          cmp_count = 0;
	wire logic   sck_w = sck_oe_out ? sck_out : sck_far;
	wire logic   mosi_w = mosi_oe_out ? mosi_out : mosi_far;
	wire logic   miso_w = miso_oe_out ? miso_out : miso_far;
	wire logic   nss_w = nss_oe_out ? nss_out : nss_far;

	always #10 clk_sys_in = ~clk_sys_in;

	spi_control_flags dut (.clk_sys_in, .nrst_in, .awaddr_in, .awvalid_in,
		.awready_out, .wdata_in, .wstrb_in, .wvalid_in, .wready_out,
		.bresp_out, .bvalid_out, .bready_in, .araddr_in, .arvalid_in,
		.arready_out, .rdata_out, .rresp_out, .rvalid_out, .rready_in,
		.sck_in(sck_w), .sck_out, .sck_oe_out, .mosi_in(mosi_w), .mosi_out,
		.mosi_oe_out, .miso_in(miso_w), .miso_out, .miso_oe_out,
		.nss_in(nss_w), .nss_out, .nss_oe_out, .irq_out);

	spi_far_end far (.sck_w, .mosi_w, .nss_w, .sck_far, .mosi_far, .nss_far,
		.miso_far, .rx_byte);

	task automatic results();
		$display("counts: %0d compared, %0d mismatched", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results

	task automatic timeout();
		num_errors++;
		$display("mismatch at %0t: wait ran out", $time);
		results();
	endtask : timeout

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = 2'h0);
		int n;
		@(posedge clk_sys_in);
		awaddr_in <= a;
		wdata_in <= d;
		awvalid_in <= 1'b1;
		wvalid_in <= 1'b1;
		bready_in <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys_in);
			if (awready_out) awvalid_in <= 1'b0;
			if (wready_out) wvalid_in <= 1'b0;
			if (bvalid_out) break;
		end
		bready_in <= 1'b0;
		if (n == 50) timeout();
		chk(32'(bresp_out), 32'(er));
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] m = 32'hffffffff, input logic [1:0] er = 2'h0);
		int n;
		@(posedge clk_sys_in);
		araddr_in <= a;
		arvalid_in <= 1'b1;
		rready_in <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys_in);
			if (arready_out) arvalid_in <= 1'b0;
			if (rvalid_out) break;
		end
		rready_in <= 1'b0;
		if (n == 50) timeout();
		chk(rdata_out & m, exp);
		chk(32'(rresp_out), 32'(er));
	endtask : rd

	task automatic wait_irq();
		int n;
		for (n = 0; n < 400 && irq_out !== 1'b1; n++) @(posedge clk_sys_in);
		if (n == 400) timeout();
	endtask : wait_irq

	task automatic t_reset();
		rd(8'h00, 32'h06);
		chk(32'(nss_oe_out), 32'h0);
		rd(8'h08, 32'h07);
		rd(8'h10, 32'h0, 32'hffffffff, 2'h2);
		wr(8'h10, 32'hff, 2'h2);
		$display("test reset done");
	endtask : t_reset

	task automatic t_modes();
		logic [1:0] m;
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			wr(8'h00, {28'h0, m, 2'h0});
			repeat (2) @(posedge clk_sys_in);
			chk({nss_oe_out, nss_oe_out & nss_out}, {m[1], m[1] & m[0]});
		end
		$display("test modes done");
	endtask : t_modes

	task automatic t_master();
		wr(8'h08, 32'h40);
		wr(8'h0c, 32'h80);
		wr(8'h00, 32'h09);
		wr(8'h04, 32'ha5);
		chk({30'h0, sck_oe_out, mosi_oe_out}, 32'h3);
		wr(8'h04, 32'h3c);
		rd(8'h00, 32'h09);
		wr(8'h04, 32'hff);
		rd(8'h00, 32'h49);
		chk(32'(irq_out), 32'h0);
		wait_irq();
		chk(32'(rx_byte), 32'ha5);
		rd(8'h00, 32'hcb);
		wr(8'h00, 32'h89);
		repeat (2) @(posedge clk_sys_in);
		chk(32'(irq_out), 32'h0);
		wait_irq();
		chk(32'(rx_byte), 32'h3c);
		wr(8'h00, 32'hf5);
		// The select pin is released, so its de-glitched level lags a while.
		repeat (12) @(posedge clk_sys_in);
		wr(8'h00, 32'h25);
		rd(8'h00, 32'h07);
		$display("test master done");
	endtask : t_master

	task automatic t_fault();
		wr(8'h0c, 32'h20);
		far.select(1'b0);
		repeat (20) @(posedge clk_sys_in);
		rd(8'h00, 32'h27);
		chk(32'(irq_out), 32'h1);
		far.select(1'b1);
		wr(8'h08, 32'h00);
		wr(8'h00, 32'h25);
		rd(8'h00, 32'h07);
		$display("test fault done");
	endtask : t_fault

	task automatic t_slave();
		wr(8'h0c, 32'h90);
		// Master transfers left the receive buffer full; drain it first.
		rd(8'h04, 32'h0, 32'h0);
		far.select(1'b0);
		repeat (20) @(posedge clk_sys_in);
		rd(8'h08, 32'h09, 32'h4d);
		chk(32'(miso_oe_out), 32'h1);
		far.send(8'h5a);
		far.send(8'hc3);
		repeat (10) @(posedge clk_sys_in);
		rd(8'h00, 32'h97);
		chk(32'(irq_out), 32'h1);
		rd(8'h04, 32'h5a);
		$display("test slave done");
	endtask : t_slave

	initial begin
		repeat (10) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		t_reset();
		t_modes();
		t_master();
		t_fault();
		t_slave();
		results();
	end
endmodule : spi_control_flags_tb
